// >>> core/pcrb_i2c_slave.sv
// Serial slave engine: address match, index byte, data bytes, read back
`timescale 1ns/10ps
`include "pcrb_defs.svh"
module pcrb_i2c_slave (
  input  wire logic       clk_i,
  input  wire logic       nrst_i,
  input  wire logic       ce_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_oe_o,
  pcrb_regif.engine       reg_if
);
  import pcrb_pkg::*;
  logic [2:0]     scl_sh_ff;
  logic [2:0]     sda_sh_ff;
  pcrb_state_type st_ff;
  logic [3:0]     bit_ff;
  logic [7:0]     sh_ff;
  logic           ack_ff;
  logic           rw_ff;
  logic [7:0]     idx_ff;
  logic           sda_oe_ff;
  logic           scl_rise, scl_fall, start_c, stop_c;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      scl_sh_ff <= 3'h7;
      sda_sh_ff <= 3'h7;
    end else if (ce_i) begin
      scl_sh_ff <= {scl_sh_ff[1:0], scl_i};
      sda_sh_ff <= {sda_sh_ff[1:0], sda_i};
    end
  end
  // Stage 0 only feeds stage 1; edges are judged on stages 1 and 2
  assign scl_rise = scl_sh_ff[1] & ~scl_sh_ff[2];
  assign scl_fall = ~scl_sh_ff[1] & scl_sh_ff[2];
  assign start_c  = scl_sh_ff[1] & scl_sh_ff[2] & ~sda_sh_ff[1] & sda_sh_ff[2];
  assign stop_c   = scl_sh_ff[1] & scl_sh_ff[2] & sda_sh_ff[1] & ~sda_sh_ff[2];

  assign reg_if.index = idx_ff;
  assign reg_if.wdata = sh_ff;
  assign sda_oe_o     = sda_oe_ff;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_ff     <= ST_IDLE;
      bit_ff    <= 4'h0;
      sh_ff     <= 8'h00;
      ack_ff    <= 1'b0;
      rw_ff     <= 1'b0;
      idx_ff    <= 8'h00;
      sda_oe_ff <= 1'b0;
      reg_if.wr <= 1'b0;
      reg_if.rd <= 1'b0;
    end else if (ce_i) begin
      reg_if.wr <= 1'b0;
      reg_if.rd <= 1'b0;
      if (start_c) begin
        st_ff     <= ST_ADDR;
        bit_ff    <= 4'h0;
        ack_ff    <= 1'b0;
        sda_oe_ff <= 1'b0;
      end else if (stop_c) begin
        st_ff     <= ST_IDLE;
        sda_oe_ff <= 1'b0;
      end else if (st_ff != ST_IDLE && st_ff != ST_SKIP) begin
        if (scl_rise && !ack_ff && st_ff != ST_RDAT) begin
          sh_ff  <= {sh_ff[6:0], sda_sh_ff[1]};
          bit_ff <= bit_ff + 4'h1;
        end else if (scl_rise && !ack_ff) begin
          bit_ff <= bit_ff + 4'h1;
        end else if (scl_rise && ack_ff && st_ff == ST_RDAT) begin
          // Master NACK ends the read
          if (sda_sh_ff[1]) st_ff <= ST_SKIP;
        end else if (scl_fall && ack_ff) begin
          ack_ff    <= 1'b0;
          bit_ff    <= 4'h0;
          sda_oe_ff <= 1'b0;
          if (st_ff == ST_RDAT) begin
            sh_ff     <= reg_if.rdata;
            sda_oe_ff <= ~reg_if.rdata[7];
          end
        end else if (scl_fall && bit_ff == 4'h8) begin
          ack_ff <= 1'b1;
          unique case (st_ff)
            ST_ADDR: begin
              if (sh_ff[7:1] == `PCRB_I2C_ADDR) begin
                sda_oe_ff <= 1'b1;
                rw_ff     <= sh_ff[0];
                if (sh_ff[0]) begin
                  st_ff     <= ST_RDAT;
                  reg_if.rd <= 1'b1;
                end else begin
                  st_ff <= ST_INDX;
                end
              end else begin
                st_ff <= ST_SKIP;
              end
            end
            ST_INDX: begin
              idx_ff    <= sh_ff;
              sda_oe_ff <= 1'b1;
              st_ff     <= ST_WDAT;
            end
            ST_WDAT: begin
              reg_if.wr <= 1'b1;
              sda_oe_ff <= 1'b1;
            end
            ST_RDAT: sda_oe_ff <= 1'b0;
            default: st_ff <= ST_IDLE;
          endcase
        end else if (scl_fall && st_ff == ST_RDAT && bit_ff != 4'h0) begin
          sh_ff     <= {sh_ff[6:0], 1'b1};
          sda_oe_ff <= ~sh_ff[6];
        end
      end
    end
  end

  // Drive only while acknowledging or sending a zero
  sda_idle_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (st_ff == ST_IDLE) |=> !sda_oe_ff || $past(st_ff) != ST_IDLE)
    else $error("SDA driven while idle");
endmodule : pcrb_i2c_slave

// >>> core/pcrb_reg_bank.sv
// Power unit control register bank with start delay sequencer
//
// Summary of operation
// R1 - Thermal warning readable at status bit one
// R2 - Delay field selects staggered start sequence
// R3 - Code 111 starts at 2,3,6,11 ms
// R4 - Code 000 starts all at 1 ms
// R5 - Code 110 starts at 3,2,1,1.5 ms
// R6 - Forced switching bits per buck, default on
// R7 - Enable bits 6,4,2,0 reset to one
// R8 - Valid flags plus both-bucks, both-linregs aggregates
// R9 - Target select bits choose target register
// R10 - Ramp go bits hold or ramp
// R11 - Write: address, index byte, then data
// R12 - Reserved and read-only bits ignore writes
`timescale 1ns/10ps
`include "pcrb_defs.svh"
module pcrb_reg_bank #(
  parameter logic [2:0] DLY_DEFAULT   = 3'h0,
  parameter logic [1:0] FPWM_DEFAULT  = 2'h3,
  parameter int         TICK_CYC      = `PCRB_TICK_CYC
) (
  input  wire logic                SYS_CLK_I,
  input  wire logic                NRST_I,
  input  wire logic                CE_I,
  input  wire logic                SCL_I,
  input  wire logic                SDA_I,
  output logic                     SDA_O,
  output logic                     SDA_OE_O,
  input  wire logic                GLOBAL_EN_I,
  input  wire logic                OVER_TEMP_I,
  input  wire logic [3:0]          OUT_VALID_I,
  output pcrb_pkg::pcrb_byte_type  START_O,
  output logic                     BUCK_ONE_FORCED_SWITCHING_O,
  output logic                     BUCK_TWO_FORCED_SWITCHING_O,
  output logic                     BUCK_ONE_TARGET_SELECT_O,
  output logic                     BUCK_TWO_TARGET_SELECT_O,
  output logic                     BUCK_ONE_RAMP_GO_O,
  output logic                     BUCK_TWO_RAMP_GO_O
);
  import pcrb_pkg::*;

  if (TICK_CYC < 1 || TICK_CYC > 65536) begin : g_tick_check
    $error("TICK_CYC must lie between 1 and 65536");
  end

  pcrb_regif   rif ();
  logic [2:0]  temp_sh_ff;
  logic [2:0]  gen_sh_ff;
  logic [3:0]  v_sh0_ff;
  logic [3:0]  v_sh1_ff;
  logic [7:0]  sysctl_ff;
  logic [7:0]  enable_ff;
  logic [7:0]  vchg_ff;
  logic [7:0]  rdata_ff;
  logic [15:0] tick_cnt_ff;
  logic [4:0]  half_ms_ff;
  logic [3:0]  started_ff;
  logic [4:0]  dly [4];
  logic [3:0]  vld;

  ////////////////////////////////////////////////////////////////////
  pcrb_i2c_slave u_slave (
    .clk_i    (SYS_CLK_I),
    .nrst_i   (NRST_I),
    .ce_i     (CE_I),
    .scl_i    (SCL_I),
    .sda_i    (SDA_I),
    .sda_oe_o (SDA_OE_O),
    .reg_if   (rif.engine)
  );
  assign SDA_O = 1'b0;

  // Pin synchronisers; stage 0 feeds stage 1 only
  always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      temp_sh_ff <= 3'h0;
      gen_sh_ff  <= 3'h0;
      v_sh0_ff   <= 4'h0;
      v_sh1_ff   <= 4'h0;
    end else if (CE_I) begin
      temp_sh_ff <= {temp_sh_ff[1:0], OVER_TEMP_I};
      gen_sh_ff  <= {gen_sh_ff[1:0], GLOBAL_EN_I};
      v_sh0_ff   <= OUT_VALID_I;
      v_sh1_ff   <= v_sh0_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Writable registers
  always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      sysctl_ff <= `PCRB_SYSCTL_RSV | {1'b0, DLY_DEFAULT, 1'b0,
                                       FPWM_DEFAULT, 1'b0};           // [R6]
      enable_ff <= `PCRB_ENABLE_RST;                                  // [R7]
      vchg_ff   <= 8'h00;                                             // [R10]
    end else if (CE_I) begin
      if (rif.wr) begin                                               // [R11]
        unique case (rif.index)
          `PCRB_OFS_SYSCTL: sysctl_ff <= {1'b0, rif.wdata[6:4], 1'b1,
                                          rif.wdata[2:1], 1'b0};      // [R12]
          `PCRB_OFS_ENABLE: enable_ff <= rif.wdata & `PCRB_ENABLE_MASK; // [R12]
          `PCRB_OFS_VCHG:   vchg_ff   <= rif.wdata & `PCRB_VCHG_MASK; // [R9] [R12]
          default: ;                                                  // [R12]
        endcase
      end
    end
  end

  logic [7:0] sysctl_eff;
  assign sysctl_eff = sysctl_ff;

  ////////////////////////////////////////////////////////////////////
  // Read path
  assign vld = v_sh1_ff;
  always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rdata_ff <= 8'h00;
    end else if (CE_I && rif.rd) begin
      unique case (rif.index)
        `PCRB_OFS_THERM:  rdata_ff <= {6'h00, temp_sh_ff[2], 1'b0};  // [R1]
        `PCRB_OFS_SYSCTL: rdata_ff <= sysctl_eff;
        `PCRB_OFS_ENABLE: rdata_ff <= enable_ff;
        `PCRB_OFS_VALID:  rdata_ff <= {vld[0] & vld[1], vld[2] & vld[3],
                                       vld[3], vld[2], 1'b0, vld[1],
                                       1'b0, vld[0]};                 // [R8]
        `PCRB_OFS_VCHG:   rdata_ff <= vchg_ff;
        default:          rdata_ff <= 8'h00;
      endcase
    end
  end
  assign rif.rdata = rdata_ff;

  ////////////////////////////////////////////////////////////////////
  // Start delay sequencer in half-millisecond ticks; order b1,b2,l1,l2
  always_comb begin
    unique case (sysctl_eff[6:4])                                     // [R2]
      3'h0: dly = '{5'd2, 5'd2, 5'd2, 5'd2};                           // [R4]
      3'h1: dly = '{5'd2, 5'd3, 5'd4, 5'd4};
      3'h2: dly = '{5'd3, 5'd4, 5'd6, 5'd12};
      3'h3: dly = '{5'd3, 5'd4, 5'd2, 5'd2};
      3'h4: dly = '{5'd3, 5'd4, 5'd6, 5'd12};
      3'h5: dly = '{5'd3, 5'd3, 5'd4, 5'd4};
      3'h6: dly = '{5'd6, 5'd4, 5'd2, 5'd3};                           // [R5]
      3'h7: dly = '{5'd4, 5'd6, 5'd12, 5'd22};                         // [R3]
    endcase
  end

  always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      tick_cnt_ff <= 16'h0000;
      half_ms_ff  <= 5'h00;
      started_ff  <= 4'h0;
    end else if (CE_I) begin
      if (!gen_sh_ff[2]) begin
        tick_cnt_ff <= 16'h0000;
        half_ms_ff  <= 5'h00;
        started_ff  <= 4'h0;
      end else begin
        if (tick_cnt_ff == 16'(TICK_CYC - 1)) begin
          tick_cnt_ff <= 16'h0000;
          if (half_ms_ff != 5'h1f) half_ms_ff <= half_ms_ff + 5'h01;
        end else begin
          tick_cnt_ff <= tick_cnt_ff + 16'h0001;
        end
        for (int i = 0; i < 4; i++) begin
          if (half_ms_ff >= dly[i]) started_ff[i] <= 1'b1;            // [R2]
        end
      end
    end
  end

  // Start gated by enable bits: b1 d0, b2 d2, l1 d4, l2 d6
  assign START_O = {4'h0, started_ff[3] & enable_ff[6], started_ff[2] & enable_ff[4],
                    started_ff[1] & enable_ff[2], started_ff[0] & enable_ff[0]}; // [R7]
  assign BUCK_ONE_FORCED_SWITCHING_O = sysctl_eff[`PCRB_B1_FORCED_BIT]; // [R6]
  assign BUCK_TWO_FORCED_SWITCHING_O = sysctl_eff[`PCRB_B2_FORCED_BIT]; // [R6]
  assign BUCK_ONE_TARGET_SELECT_O    = vchg_ff[1];                    // [R9]
  assign BUCK_TWO_TARGET_SELECT_O    = vchg_ff[5];                    // [R9]
  assign BUCK_ONE_RAMP_GO_O          = vchg_ff[0];                    // [R10]
  assign BUCK_TWO_RAMP_GO_O          = vchg_ff[4];                    // [R10]

  ////////////////////////////////////////////////////////////////////
  enable_rst_a: assert property (@(posedge SYS_CLK_I)                 // [R7]
    $rose(NRST_I) |-> enable_ff == 8'h55) else $error("Enable reset wrong");
  no_start_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I) // [R2]
    (CE_I && !gen_sh_ff[2]) |=> started_ff == 4'h0) else $error("Start without enable");
  vchg_rsv_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I) // [R12]
    (vchg_ff & 8'hcc) == 8'h00) else $error("Reserved bits set");
  early_start_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I) // [R3]
    (sysctl_eff[6:4] == 3'h7 && half_ms_ff < 5'd4 && gen_sh_ff[2]) |-> !started_ff[0])
    else $error("Buck one started early");
  write_lands_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I) // [R11]
    (CE_I && rif.wr && rif.index == `PCRB_OFS_VCHG) |=> vchg_ff == ($past(rif.wdata) & 8'h33))
    else $error("Write not stored");
  aggr_flag_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I) // [R8]
    (CE_I && rif.rd && rif.index == `PCRB_OFS_VALID) |=> rdata_ff[7] == (rdata_ff[2] & rdata_ff[0]))
    else $error("Aggregate flag wrong");
  therm_read_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I) // [R1]
    (CE_I && rif.rd && rif.index == `PCRB_OFS_THERM) |=> rdata_ff[7:2] == 6'h00 && !rdata_ff[0])
    else $error("Thermal reserved bits");
  fpwm_out_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I) // [R6]
    BUCK_ONE_FORCED_SWITCHING_O == sysctl_eff[1]) else $error("Forced switching wrong");
  // Sequencer thresholds, read-path and reserved-bit guards
  all_start_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I) // [R4]
    (CE_I && gen_sh_ff[2] && sysctl_eff[6:4] == 3'h0 && half_ms_ff >= 5'd2) |=> &started_ff)
    else $error("Code zero start incomplete");
  swap_start_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I) // [R5]
    (CE_I && gen_sh_ff[2] && sysctl_eff[6:4] == 3'h6 && half_ms_ff >= 5'd4)
    |=> started_ff[3:1] == 3'h7) else $error("Code six order wrong");
  unmapped_read_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I) // [R12]
    (CE_I && rif.rd && !(rif.index inside {`PCRB_OFS_THERM, `PCRB_OFS_SYSCTL,
      `PCRB_OFS_ENABLE, `PCRB_OFS_VALID, `PCRB_OFS_VCHG})) |=> rdata_ff == 8'h00)
    else $error("Unmapped index read nonzero");
  linreg_aggr_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I) // [R8]
    (CE_I && rif.rd && rif.index == `PCRB_OFS_VALID) |=> rdata_ff[6] == (rdata_ff[5] & rdata_ff[4]))
    else $error("Linreg aggregate flag wrong");
  sysctl_rsv_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I) // [R12]
    sysctl_ff[7] == 1'b0 && sysctl_ff[3] && !sysctl_ff[0]) else $error("Control reserved bits");
  tick_range_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I) // [R2]
    int'(tick_cnt_ff) < TICK_CYC) else $error("Tick counter out of range");
endmodule : pcrb_reg_bank

// >>> pkg/pcrb_defs.svh
// Register offsets, field positions, reset values and timing constants
`ifndef PCRB_DEFS_SVH
`define PCRB_DEFS_SVH
`define PCRB_I2C_ADDR       7'h59
`define PCRB_OFS_THERM      8'h02
`define PCRB_OFS_SYSCTL     8'h07
`define PCRB_OFS_ENABLE     8'h10
`define PCRB_OFS_VALID      8'h11
`define PCRB_OFS_VCHG       8'h20
`define PCRB_THERM_BIT      1
`define PCRB_DLY_LSB        4
`define PCRB_B2_FORCED_BIT  2
`define PCRB_B1_FORCED_BIT  1
`define PCRB_SYSCTL_RSV     8'h08
`define PCRB_ENABLE_RST     8'h55
`define PCRB_ENABLE_MASK    8'h55
`define PCRB_VCHG_MASK      8'h33
`define PCRB_CLK_HZ         25000000
`define PCRB_TICK_US        500
`define PCRB_TICK_CYC       ((`PCRB_CLK_HZ / 1000) * `PCRB_TICK_US / 1000)
`endif

// >>> pkg/pcrb_pkg.sv
// Types shared by the register bank and its serial engine
package pcrb_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_INDX = 3'b010,
    ST_WDAT = 3'b011,
    ST_RDAT = 3'b100,
    ST_SKIP = 3'b101
  } pcrb_state_type;
  typedef logic [7:0] pcrb_byte_type;
endpackage : pcrb_pkg

// >>> pkg/pcrb_regif.sv
// Register access carrier between serial engine and register bank
`timescale 1ns/10ps
interface pcrb_regif;
  logic [7:0] index;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  modport engine (output index, output wdata, output wr, output rd, input rdata);
  modport bank   (input index, input wdata, input wr, input rd, output rdata);
endinterface : pcrb_regif

// >>> verification/pcrb_host.sv
// Serial host model: drives clock and open-drain data toward the bank
`timescale 1ns/10ps
`include "pcrb_defs.svh"
module pcrb_host (
  output logic      scl_o,
  output logic      sda_low_o,
  input  wire logic sda_i
);
  localparam time HP = 400ns;

  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end

  ////////////////////////////////////////
  task automatic start();
    #(HP/2);
    sda_low_o = 1'b0;
    #(HP/2);
    scl_o = 1'b1;
    #HP;
    sda_low_o = 1'b1;
    #HP;
    scl_o = 1'b0;
  endtask : start

  task automatic stop();
    #(HP/2);
    sda_low_o = 1'b1;
    #(HP/2);
    scl_o = 1'b1;
    #HP;
    sda_low_o = 1'b0;
    #HP;
  endtask : stop

  // Data moves only while the clock is low
  task automatic bit_io(input logic b, output logic r);
    #(HP/2);
    sda_low_o = ~b;
    #(HP/2);
    scl_o = 1'b1;
    #HP;
    r = sda_i;
    scl_o = 1'b0;
  endtask : bit_io

  task automatic xfer(input logic [7:0] d, input logic hold, output logic [7:0] q,
                      output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(~hold, ack);
    ack = ~ack;
  endtask : xfer

  ////////////////////////////////////////
  task automatic wr(input logic [6:0] a, input logic [7:0] idx, d, output logic ok);
    logic [7:0] q;
    logic       k0, k1, k2;
    start();
    xfer({a, 1'b0}, 1'b0, q, k0);
    xfer(idx, 1'b0, q, k1);
    xfer(d, 1'b0, q, k2);
    stop();
    ok = k0 & k1 & k2;
  endtask : wr

  task automatic rd(input logic [7:0] idx, output logic [7:0] q);
    logic [7:0] z;
    logic       k;
    start();
    xfer({`PCRB_I2C_ADDR, 1'b0}, 1'b0, z, k);
    xfer(idx, 1'b0, z, k);
    start();
    xfer({`PCRB_I2C_ADDR, 1'b1}, 1'b0, z, k);
    xfer(8'hff, 1'b0, q, k);
    stop();
  endtask : rd
endmodule : pcrb_host

// >>> verification/pcrb_reg_bank_bench.sv
// Bench for the register bank: access table, then sequencing and reset
`timescale 1ns/10ps
`include "pcrb_defs.svh"
module pcrb_reg_bank_bench;
  import pcrb_pkg::*;
  typedef struct {
    logic [7:0] idx;
    logic [7:0] wd;
    logic [7:0] rd;
    logic [5:0] o;
  } pcrb_row_type;
  localparam int TK = 4;
  logic          clk = 1'b0;
  logic          nrst = 1'b0;
  logic          ce = 1'b1;
  logic          gen = 1'b0;
  logic          otemp = 1'b0;
  logic [3:0]    valid = 4'h0;
  logic          scl, sda_low, sda_oe, sda_w, sda_zero;
  pcrb_byte_type start_v;
  logic [5:0]    outs;
  int            error_cnt = 0;
  int            checks = 0;
  pcrb_row_type  rows [13] = '{'{8'h07, 8'hff, 8'h7e, 6'h30}, '{8'h07, 8'h04, 8'h0c, 6'h20},
    '{8'h07, 8'h02, 8'h0a, 6'h10}, '{8'h20, 8'h33, 8'h33, 6'h1f}, '{8'h20, 8'h12, 8'h12, 6'h16},
    '{8'h20, 8'hff, 8'h33, 6'h1f}, '{8'h20, 8'h00, 8'h00, 6'h10}, '{8'h10, 8'hff, 8'h55, 6'h10},
    '{8'h10, 8'h14, 8'h14, 6'h10}, '{8'h02, 8'hff, 8'h00, 6'h10}, '{8'h11, 8'hff, 8'h00, 6'h10},
    '{8'h30, 8'hff, 8'h00, 6'h10}, '{8'h10, 8'h55, 8'h55, 6'h10}};
  int dl [8][4] = '{'{2, 2, 2, 2}, '{2, 3, 4, 4}, '{3, 4, 6, 12}, '{3, 4, 2, 2},
                    '{3, 4, 6, 12}, '{3, 3, 4, 4}, '{6, 4, 2, 3}, '{4, 6, 12, 22}};
  logic [11:0] vt [4] = '{12'h511, 12'h385, 12'hc70, 12'hff5};

  always #20 clk = ~clk;
  assign sda_w = ~(sda_low | sda_oe);

  pcrb_reg_bank #(.TICK_CYC(TK)) DUT (
    .SYS_CLK_I(clk), .NRST_I(nrst), .CE_I(ce), .SCL_I(scl), .SDA_I(sda_w),
    .SDA_O(sda_zero), .SDA_OE_O(sda_oe), .GLOBAL_EN_I(gen), .OVER_TEMP_I(otemp),
    .OUT_VALID_I(valid), .START_O(start_v), .BUCK_ONE_FORCED_SWITCHING_O(outs[4]),
    .BUCK_TWO_FORCED_SWITCHING_O(outs[5]), .BUCK_ONE_TARGET_SELECT_O(outs[2]),
    .BUCK_TWO_TARGET_SELECT_O(outs[3]), .BUCK_ONE_RAMP_GO_O(outs[0]),
    .BUCK_TWO_RAMP_GO_O(outs[1]));
  pcrb_host host (.scl_o(scl), .sda_low_o(sda_low), .sda_i(sda_w));

  ////////////////////////////////////////
  task automatic chk(input logic [7:0] got, exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic chkc(input int got, exp);
    checks++;
    if (got != exp) begin
      error_cnt++;
      $display("Error at %0t: count %h expected %h", $time, got, exp);
    end
  endtask : chkc

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  task automatic rdchk(input logic [7:0] idx, exp);
    logic [7:0] q;
    host.rd(idx, q);
    chk(q, exp);
  endtask : rdchk

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : report_and_stop

  ////////////////////////////////////////
  initial begin
    logic ok;
    int   t [4];
    step(2);
    nrst = 1'b1;
    step(4);
    rdchk(8'h02, 8'h00);
    rdchk(8'h07, 8'h0e);
    rdchk(8'h10, 8'h55);
    rdchk(8'h11, 8'h00);
    rdchk(8'h20, 8'h00);
    chk({2'h0, outs}, 8'h30);
    chk({7'h0, sda_zero}, 8'h00);
    $display("Test reset values done");
    foreach (rows[i]) begin
      host.wr(`PCRB_I2C_ADDR, rows[i].idx, rows[i].wd, ok);
      chk({7'h0, ok}, 8'h01);
      rdchk(rows[i].idx, rows[i].rd);
      chk({2'h0, outs}, {2'h0, rows[i].o});
    end
    $display("Test register table done");
    otemp = 1'b1;
    rdchk(8'h02, 8'h02);
    otemp = 1'b0;
    foreach (vt[i]) begin
      valid = vt[i][11:8];
      rdchk(8'h11, vt[i][7:0]);
    end
    host.wr(7'h5a, 8'h10, 8'h00, ok);
    chk({7'h0, ok}, 8'h00);
    rdchk(8'h10, 8'h55);
    $display("Test status and address done");
    for (int c = 0; c < 8; c++) begin
      host.wr(`PCRB_I2C_ADDR, 8'h07, {1'b0, c[2:0], 4'h6}, ok);
      gen = 1'b1;
      t = '{-1, -1, -1, -1};
      for (int n = 0; n < 200; n++) begin
        step(1);
        for (int b = 0; b < 4; b++) begin
          if (start_v[b] === 1'b1 && t[b] < 0) begin
            t[b] = n;
          end
        end
      end
      if (t[0] < 0) begin
        error_cnt++;
        report_and_stop();
      end
      gen = 1'b0;
      chkc(int'(t[0] >= (dl[c][0] - 1) * TK && t[0] <= dl[c][0] * TK + 8), 1);
      for (int b = 1; b < 4; b++) begin
        chkc(t[b] - t[0], (dl[c][b] - dl[c][0]) * TK);
      end
      step(6);
      chk(start_v, 8'h00);
    end
    host.wr(`PCRB_I2C_ADDR, 8'h10, 8'h15, ok);
    gen = 1'b1;
    step(100);
    chk(start_v, 8'h07);
    gen = 1'b0;
    $display("Test start sequencing done");
    host.wr(`PCRB_I2C_ADDR, 8'h20, 8'h33, ok);
    chk({7'h0, ok}, 8'h01);
    nrst = 1'b0;
    step(2);
    nrst = 1'b1;
    step(4);
    rdchk(8'h10, 8'h55);
    rdchk(8'h07, 8'h0e);
    rdchk(8'h20, 8'h00);
    $display("Test second reset done");
    ce = 1'b0;
    gen = 1'b1;
    step(30);
    chk(start_v, 8'h00);
    ce = 1'b1;
    step(30);
    chk(start_v, 8'h0f);
    gen = 1'b0;
    step(6);
    chk(start_v, 8'h00);
    $display("Test clock enable done");
    report_and_stop();
  end
endmodule : pcrb_reg_bank_bench
